// ### hdl/dbf_pkg.sv
// dbf_pkg: constants, types and register map of the per-channel debounce filter
// assumes a 25 MHz sys_clk; all counts derive from it
package dbf_pkg;

  // ------------------------------------------------------------
  // clock and time base
  // ------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int TICK_US = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;
  localparam int TICK_CNT_W = 5;
  localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(TICK_CYCLES - 1);

  // ------------------------------------------------------------
  // debounce times, in ticks of 1 us
  // ------------------------------------------------------------
  localparam int FIXED_US = 4;
  localparam int DLY10_MS = 10;
  localparam int DLY30_MS = 30;
  localparam int DLY100_MS = 100;
  localparam int CNT_W = 17;
  localparam logic [CNT_W-1:0] FIXED_TICKS = CNT_W'(FIXED_US / TICK_US);
  localparam logic [CNT_W-1:0] DLY0_TICKS = CNT_W'(0);
  localparam logic [CNT_W-1:0] DLY10_TICKS = CNT_W'(DLY10_MS * 1000 / TICK_US);
  localparam logic [CNT_W-1:0] DLY30_TICKS = CNT_W'(DLY30_MS * 1000 / TICK_US);
  localparam logic [CNT_W-1:0] DLY100_TICKS = CNT_W'(DLY100_MS * 1000 / TICK_US);

  // ------------------------------------------------------------
  // channels and register map
  // ------------------------------------------------------------
  localparam int NUM_CH = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] REG_CFG0 = 8'h00;
  localparam logic [ADDR_W-1:0] REG_CFG1 = 8'h01;
  localparam logic [ADDR_W-1:0] REG_CFG2 = 8'h02;
  localparam logic [ADDR_W-1:0] REG_CFG3 = 8'h03;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [DATA_W-1:0] CFG_RESET = 8'h00;
  // each config byte holds two channels: low nibble even, high nibble odd
  localparam int FLD_DLY_LSB = 0;
  localparam int FLD_MODE_LSB = 2;
  localparam int FLD_W = 4;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    DBF_DLY_0 = 2'b00,
    DBF_DLY_10 = 2'b01,
    DBF_DLY_30 = 2'b10,
    DBF_DLY_100 = 2'b11
  } dbf_dly_type;

  typedef enum logic [1:0] {
    DBF_MODE_DEGLITCH = 2'b00,
    DBF_MODE_LOWPASS = 2'b01,
    DBF_MODE_BLANK = 2'b10,
    DBF_MODE_BLANK_ALT = 2'b11
  } dbf_mode_type;

  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] dly;
  } dbf_cfg_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } dbf_bus_type;

endpackage : dbf_pkg

// ### hdl/dbf_chan.sv
// dbf_chan: one channel, fixed stage followed by the selectable stage
// assumes din is already synchronised to sys_clk and tick is a one-cycle pulse
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module dbf_chan
  import dbf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic tick,
  input wire logic lowpass_only,
  input wire logic high_speed,
  input wire dbf_cfg_type cfg,
  input wire logic din,
  output logic dout
);

  logic fix_out_reg;
  logic [CNT_W-1:0] fix_cnt_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] target;
  logic [1:0] mode;
  logic filt_out_reg;

  // ------------------------------------------------------------
  // fixed low-pass stage
  // ------------------------------------------------------------
  // up/down counter towards the fixed time
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fix_cnt_reg <= '0;
      fix_out_reg <= 1'b0;
    end else if (tick) begin
      if (din != fix_out_reg) begin // R2
        if (fix_cnt_reg + CNT_W'(1) >= FIXED_TICKS) begin
          fix_out_reg <= din;
          fix_cnt_reg <= '0;
        end else begin
          fix_cnt_reg <= fix_cnt_reg + CNT_W'(1);
        end
      end else if (fix_cnt_reg != '0) begin
        fix_cnt_reg <= fix_cnt_reg - CNT_W'(1);
      end
    end
  end

  // delay code to tick count
  always_comb begin
    unique case (cfg.dly) // R1 R17
      DBF_DLY_0: target = DLY0_TICKS;
      DBF_DLY_10: target = DLY10_TICKS;
      DBF_DLY_30: target = DLY30_TICKS;
      DBF_DLY_100: target = DLY100_TICKS;
    endcase
  end

  // parallel variant forces low-pass
  assign mode = lowpass_only ? DBF_MODE_LOWPASS : cfg.mode; // R5

  // ------------------------------------------------------------
  // selectable stage
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_reg <= '0; // R10 R17
      filt_out_reg <= 1'b0;
    end else if (target == '0) begin
      filt_out_reg <= fix_out_reg;
      cnt_reg <= '0;
    end else if (tick) begin
      if (mode == DBF_MODE_DEGLITCH) begin // R3
        // restart on any change, copy once stable
        if (fix_out_reg == filt_out_reg) begin
          cnt_reg <= '0;
        end else if (cnt_reg + CNT_W'(1) >= target) begin // R6
          filt_out_reg <= fix_out_reg;
          cnt_reg <= '0;
        end else begin
          cnt_reg <= cnt_reg + CNT_W'(1);
        end
      end else if (mode == DBF_MODE_LOWPASS) begin
        if (fix_out_reg != filt_out_reg) begin
          if (cnt_reg + CNT_W'(1) >= target) begin // R9
            filt_out_reg <= fix_out_reg;
            cnt_reg <= '0;
          end else begin
            cnt_reg <= cnt_reg + CNT_W'(1); // R7
          end
        end else if (cnt_reg != '0) begin
          cnt_reg <= cnt_reg - CNT_W'(1); // R8
        end
      end else begin
        // blanking: follow at once, then blind for the debounce time
        if (cnt_reg != '0) begin
          cnt_reg <= cnt_reg - CNT_W'(1); // R12
        end else if (fix_out_reg != filt_out_reg) begin // R11 R13 R14
          filt_out_reg <= fix_out_reg;
          cnt_reg <= target;
        end
      end
    end
  end

  // output register, high-speed channels bypass every stage
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dout <= 1'b0;
    end else begin
      dout <= high_speed ? din : filt_out_reg; // R15
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  AST_HS_BYPASS: assert property (@(posedge sys_clk) disable iff (sys_rst) // R15
    high_speed |=> dout == $past(din))
    else $error("high-speed channel not bypassed");

  AST_BLANK_HOLD: assert property (@(posedge sys_clk) disable iff (sys_rst) // R12
    (mode[1] && target != '0 && cnt_reg != '0 && $stable(mode) && $stable(target)) |=> $stable(filt_out_reg))
    else $error("blanking output changed while blind");

  AST_BLANK_LOAD: assert property (@(posedge sys_clk) disable iff (sys_rst) // R11 R13 R14
    (mode[1] && target != '0 && tick && cnt_reg == '0 && fix_out_reg != filt_out_reg) |=> cnt_reg == $past(target))
    else $error("blanking counter not loaded");

  AST_LP_DOWN: assert property (@(posedge sys_clk) disable iff (sys_rst) // R8
    (mode == DBF_MODE_LOWPASS && target != '0 && tick && fix_out_reg == filt_out_reg && cnt_reg != '0)
      |=> cnt_reg == $past(cnt_reg) - CNT_W'(1))
    else $error("low-pass counter did not decrement");

  AST_LP_UP: assert property (@(posedge sys_clk) disable iff (sys_rst) // R7
    (mode == DBF_MODE_LOWPASS && target != '0 && tick && fix_out_reg != filt_out_reg && cnt_reg + CNT_W'(1) < target)
      |=> cnt_reg == $past(cnt_reg) + CNT_W'(1) && $stable(filt_out_reg))
    else $error("low-pass counter did not increment");

  AST_DG_RESTART: assert property (@(posedge sys_clk) disable iff (sys_rst) // R6
    (mode == DBF_MODE_DEGLITCH && target != '0 && tick && fix_out_reg == filt_out_reg) |=> cnt_reg == '0)
    else $error("deglitch counter not restarted");

endmodule : dbf_chan

// ### hdl/dbf_top.sv
// dbf_top: eight-channel debounce filter with its configuration registers
// assumes field inputs are asynchronous; register port is on sys_clk
// Contract
// R1 - delay code 00/01/10/11 adds 0/10/30/100 ms of debounce time.
// R2 - every low-speed channel always passes a fixed 4 us low-pass stage first.
// R3 - mode 00 is deglitch, 01 is low-pass, 1x is blanking.
// R4 - each of the eight channels has its own mode and delay code.
// R5 - the parallel-output variant runs every low-speed channel in low-pass only.
// R6 - deglitch copies the input only after it stays unchanged for the full debounce time.
// R7 - low-pass counts up while the input differs from the output.
// R8 - low-pass counts down while the input equals the output, keeping the credit.
// R9 - low-pass output takes the input once the count reaches the debounce time.
// R10 - the blanking counter starts at zero.
// R11 - blanking follows a change at once when the counter is zero and loads it.
// R12 - blanking counts down every tick and ignores the input meanwhile.
// R13 - at blanking expiry a differing input is taken at once and the counter reloaded.
// R14 - at blanking expiry with equal input the next change is taken at once and reloads.
// R15 - high-speed channels bypass all filtering.
// R16 - settings are 32 bits in four one-byte readable and writable registers.
// R17 - counters run from a common tick, codes map to fixed counts, reset clears all.
`timescale 1ns/1ps
module dbf_top
  import dbf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic lowpass_only,
  input wire logic [NUM_CH-1:0] high_speed,
  input wire logic [NUM_CH-1:0] field_in,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  output logic [NUM_CH-1:0] filt_out
);

  logic [NUM_CH-1:0] sync1_reg;
  logic [NUM_CH-1:0] sync2_reg;
  logic [TICK_CNT_W-1:0] tick_cnt_reg;
  logic tick_reg;
  logic [DATA_W-1:0] cfg_reg [4];
  logic [NUM_CH-1:0] ch_out;
  dbf_bus_type bus;

  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // ------------------------------------------------------------
  // input synchroniser
  // ------------------------------------------------------------
  // two flops per field input
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= field_in;
      sync2_reg <= sync1_reg;
    end
  end

  // ------------------------------------------------------------
  // common time base
  // ------------------------------------------------------------
  // one pulse every microsecond
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else if (tick_cnt_reg == TICK_LAST) begin // R17
      tick_cnt_reg <= '0;
      tick_reg <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + TICK_CNT_W'(1);
      tick_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  // write decode; unmapped addresses are ignored
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) begin
        cfg_reg[i] <= CFG_RESET;
      end
    end else if (bus.wr) begin
      unique case (bus.addr) // R16
        REG_CFG0: cfg_reg[0] <= bus.wdata;
        REG_CFG1: cfg_reg[1] <= bus.wdata;
        REG_CFG2: cfg_reg[2] <= bus.wdata;
        REG_CFG3: cfg_reg[3] <= bus.wdata;
        default: ;
      endcase
    end
  end

  // read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else if (bus.rd) begin
      unique case (bus.addr) // R16
        REG_CFG0: reg_rdata <= cfg_reg[0];
        REG_CFG1: reg_rdata <= cfg_reg[1];
        REG_CFG2: reg_rdata <= cfg_reg[2];
        REG_CFG3: reg_rdata <= cfg_reg[3];
        REG_STATUS: reg_rdata <= ch_out;
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // ------------------------------------------------------------
  // channels
  // ------------------------------------------------------------
  // one filter per channel with its own nibble
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    dbf_cfg_type ch_cfg;
    assign ch_cfg = dbf_cfg_type'(cfg_reg[g/2][(g%2)*FLD_W +: FLD_W]); // R4
    dbf_chan u_chan (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .tick(tick_reg),
      .lowpass_only(lowpass_only),
      .high_speed(high_speed[g]),
      .cfg(ch_cfg),
      .din(sync2_reg[g]),
      .dout(ch_out[g])
    );
  end

  assign filt_out = ch_out;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  AST_TICK_PERIOD: assert property (@(posedge sys_clk) disable iff (sys_rst) // R17
    tick_reg |=> !tick_reg [*8] ##1 !tick_reg [*8] ##1 !tick_reg [*8] ##1 tick_reg)
    else $error("tick spacing wrong");

  AST_CFG_WRITE: assert property (@(posedge sys_clk) disable iff (sys_rst) // R16
    (bus.wr && bus.addr == REG_CFG2) |=> cfg_reg[2] == $past(bus.wdata))
    else $error("config write lost");

  AST_RD_LATENCY: assert property (@(posedge sys_clk) disable iff (sys_rst) // R16
    (bus.rd && bus.addr == REG_CFG1 && !bus.wr) |=> reg_rdata == $past(cfg_reg[1]))
    else $error("config read wrong");

  AST_UNMAPPED_RD: assert property (@(posedge sys_clk) disable iff (sys_rst) // R16
    (bus.rd && bus.addr > REG_STATUS) |=> reg_rdata == '0)
    else $error("unmapped read not zero");

endmodule : dbf_top

// ### bench/dbf_field_model.sv
// dbf_field_model: field-side source of the eight isolated inputs
// assumes the bench sets lvl on sys_clk; contact bounce is optional
`timescale 1ns/1ps
module dbf_field_model
  import dbf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [NUM_CH-1:0] lvl,
  input wire logic bounce,
  output logic [NUM_CH-1:0] field_in
);
  logic [NUM_CH-1:0] last_reg = '0;
  logic [NUM_CH-1:0] mask_reg = '0;
  logic [2:0] bcnt_reg = 3'h0;

  // ------------------------------------------------------------
  // bounce shaping
  // ------------------------------------------------------------
  // changed channels chatter for six cycles before settling
  always @(posedge sys_clk) begin
    last_reg <= lvl;
    if (bounce && (lvl != last_reg)) begin
      mask_reg <= lvl ^ last_reg;
      bcnt_reg <= 3'h6;
    end else if (bcnt_reg != 3'h0) begin
      bcnt_reg <= bcnt_reg - 3'h1;
    end
    field_in <= lvl ^ (mask_reg & {NUM_CH{bcnt_reg[0]}});
  end
endmodule : dbf_field_model

// ### bench/tb_top.sv
// tb_top: register and filter tests of the eight-channel debounce filter
// assumes a 1 us tick from sys_clk; long delay codes checked only as longer than fixed
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_mismatch++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb_top
  import dbf_pkg::*;
;
  logic sys_clk, sys_rst, lowpass_only, reg_wr, reg_rd, bounce;
  logic [NUM_CH-1:0] high_speed, field_in, filt_out, lvl;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic [DATA_W-1:0] cfg_val [4] = '{8'h91, 8'h4D, 8'h32, 8'hF0};
  int n_mismatch = 0;
  int compares = 0;

  dbf_top dbf_top_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .lowpass_only(lowpass_only),
    .high_speed(high_speed), .field_in(field_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .filt_out(filt_out));
  dbf_field_model dbf_field_model_i (.sys_clk(sys_clk), .lvl(lvl), .bounce(bounce), .field_in(field_in));

  // ------------------------------------------------------------
  // clock, watchdog and closing
  // ------------------------------------------------------------
  // 40 ns period
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // tests need about 8300 cycles
  initial begin
    #(20000 * 40);
    n_mismatch++;
    conclude();
  end

  task conclude();
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  // ------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // data stand only in the cycle after the strobe
  task chk_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask : chk_rd

  // eight periods of alternating level on channel 3
  task pat(input logic first, input int na, input int nb);
    repeat (8) begin
      @(posedge sys_clk);
      lvl[3] <= first;
      repeat (na) @(posedge sys_clk);
      lvl[3] <= ~first;
      repeat (nb - 1) @(posedge sys_clk);
    end
    #1;
  endtask : pat

  task test_end(input string name);
    $display("test %s done", name);
  endtask : test_end

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    lowpass_only = 1'b0;
    high_speed = 8'h80;
    lvl = '0;
    bounce = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 5; i++) chk_rd(ADDR_W'(i), 8'h00);
    `CHK(filt_out, 8'h00)
    for (int i = 0; i < 4; i++) wr(REG_CFG0 + ADDR_W'(i), cfg_val[i]);
    wr(REG_STATUS, 8'hFF);
    wr(8'h05, 8'hAA);
    for (int i = 0; i < 4; i++) chk_rd(REG_CFG0 + ADDR_W'(i), cfg_val[i]);
    chk_rd(REG_STATUS, 8'h00);
    chk_rd(8'h05, 8'h00);
    test_end("registers");
    // bypass channel: three cycles from field pin
    @(posedge sys_clk);
    lvl[7] <= 1'b1;
    @(field_in[7]);
    cyc(2);
    `CHK(filt_out[7], 1'b0)
    cyc(1);
    `CHK(filt_out[7], 1'b1)
    test_end("bypass");
    // all modes and codes at once, with bounce
    @(posedge sys_clk);
    bounce <= 1'b1;
    lvl <= 8'hFF;
    cyc(50);
    `CHK(filt_out, 8'h80)
    cyc(200);
    `CHK(filt_out, 8'hCE)
    @(posedge sys_clk);
    lvl <= 8'hF9;
    cyc(500);
    `CHK(filt_out, 8'hCE)
    cyc(5000);
    `CHK(filt_out, 8'hCE)
    chk_rd(REG_STATUS, 8'hCE);
    test_end("modes");
    // up and down counting with credit
    bounce <= 1'b0;
    pat(1'b0, 20, 60);
    `CHK(filt_out[3], 1'b1)
    pat(1'b0, 60, 20);
    `CHK(filt_out[3], 1'b0)
    @(posedge sys_clk);
    lvl[6] <= 1'b0;
    repeat (50) @(posedge sys_clk);
    lvl[6] <= 1'b1;
    cyc(1);
    `CHK(filt_out[6], 1'b1)
    cyc(59);
    `CHK(filt_out[6], 1'b1)
    // deglitch channel loses its count when the input falls back
    @(posedge sys_clk);
    lvl[0] <= 1'b0;
    repeat (200) @(posedge sys_clk);
    lvl[0] <= 1'b1;
    cyc(200);
    `CHK(filt_out[0], 1'b0)
    test_end("counting");
    // parallel variant after a second reset
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    lowpass_only <= 1'b1;
    cyc(3);
    `CHK(filt_out, 8'h00)
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    chk_rd(REG_CFG0, 8'h00);
    wr(REG_CFG0, 8'h91);
    @(posedge sys_clk);
    lvl[1] <= 1'b1;
    cyc(250);
    `CHK(filt_out[1], 1'b0)
    `CHK(filt_out[7], 1'b1)
    // input falls back before the low-pass target, counter winds down
    @(posedge sys_clk);
    lvl[1] <= 1'b0;
    cyc(400);
    `CHK(filt_out[1], 1'b0)
    test_end("variant");
    conclude();
  end
endmodule : tb_top
